//--- verilog/subx_regs.vh
// Behaviour
// - Plain subtract computes file register minus accumulator, any address to FFh.
// - Destination bit 0 writes the accumulator, 1 writes the file register.
// - Borrow form also subtracts one more when carry is clear.
// - Carry set before borrow form means no extra decrement applied.
// - Carry clear in borrow form means one extra subtracted; zero result sets zero flag.
// - Underflow wraps modulo 256 and clears carry to show a borrow.
// - Sleep stops the oscillator, updates power-down flag, external wake resumes.
`ifndef SUBX_REGS_VH
`define SUBX_REGS_VH

// Register byte offsets on the APB.
`define OFS_CTRL 12'h000
`define OFS_ACC 12'h004
`define OFS_STATUS 12'h008
`define OFS_FADDR 12'h00C
`define OFS_FDATA 12'h010
`define OFS_RESULT 12'h014

// Command register fields.
`define CTRL_ADDR_MSB 7
`define CTRL_ADDR_LSB 0
`define CTRL_DEST_BIT 8
`define CTRL_BORROW_BIT 9
`define CTRL_SLEEP_BIT 10

// Status register fields.
`define ST_CARRY_BIT 0
`define ST_DCARRY_BIT 1
`define ST_ZERO_BIT 2
`define ST_POWERDOWN_BIT 3
`define ST_SLEEP_BIT 4

// Reset values and fixed literals.
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h00000000
`define FLAG_RST 1'b0
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1

`endif

//--- verilog/sub_borrow_alu.v
`timescale 1ns/1ps
// Combinational 8-bit subtractor with carry-as-not-borrow convention.
module sub_borrow_alu #(
   parameter WIDTH = 8
) (
   // Operands.
   input wire [WIDTH-1:0] file_val,
   input wire [WIDTH-1:0] acc_val,
   input wire use_borrow,
   input wire carry_in,
   // Result and flags.
   output wire [WIDTH-1:0] result,
   output wire carry_out,
   output wire dcarry_out,
   output wire zero_out
);

   wire borrow_in;
   wire [WIDTH:0] full_diff;
   wire [4:0] low_diff;

   // The extra decrement applies only to the borrow form with carry clear.
   assign borrow_in = use_borrow & ~carry_in;
   // Unsigned difference one bit wider; the top bit shows a borrow.
   assign full_diff = {1'b0, file_val} - {1'b0, acc_val}
                      - {{WIDTH{1'b0}}, borrow_in};
   assign low_diff = {1'b0, file_val[3:0]} - {1'b0, acc_val[3:0]}
                     - {4'h0, borrow_in};
   assign result = full_diff[WIDTH-1:0];
   assign carry_out = ~full_diff[WIDTH];
   assign dcarry_out = ~low_diff[4];
   assign zero_out = (full_diff[WIDTH-1:0] == {WIDTH{1'b0}});

endmodule // sub_borrow_alu

//--- verilog/subtract_with_borrow_exec.v
`timescale 1ns/1ps
`include "subx_regs.vh"
// Subtract execution unit with file register array, reached over APB.
module subtract_with_borrow_exec #(
   parameter ADDR_W = 12,
   parameter FILE_DEPTH = 256
) (
   // Clock, reset and clock enable.
   input wire CLOCK,
   input wire ARST_N,
   input wire CE,
   // APB slave.
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [ADDR_W-1:0] PADDR,
   input wire [31:0] PWDATA,
   output wire [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   // Power control.
   input wire EXT_WAKE_REQ,
   output wire OSC_STOP,
   output wire POWERDOWN_FLAG,
   // Execution status.
   output wire SUB_DONE
);

   localparam BUS_IDLE = 2'b01;
   localparam BUS_ACCESS = 2'b10;

   // Bus slave state.
   reg [1:0] bus_state_reg;
   reg [1:0] bus_state_next;
   reg pready_reg;
   reg pready_next;
   reg pslverr_reg;
   reg pslverr_next;
   reg [31:0] prdata_reg;
   reg [31:0] prdata_next;

   // Core state.
   reg [7:0] acc_reg;
   reg [7:0] acc_next;
   reg carry_flag_reg;
   reg carry_flag_next;
   reg digit_carry_flag_reg;
   reg digit_carry_flag_next;
   reg zero_flag_reg;
   reg zero_flag_next;
   reg powerdown_flag_reg;
   reg powerdown_flag_next;
   reg sleep_reg;
   reg sleep_next;
   reg [7:0] faddr_reg;
   reg [7:0] faddr_next;
   reg [7:0] result_reg;
   reg [7:0] result_next;
   reg done_reg;
   reg done_next;

   // Data memory.
   reg [7:0] file_mem [0:FILE_DEPTH-1];

   wire setup_phase;
   wire access_write;
   wire addr_mapped;
   wire ctrl_write;
   wire exec_sub;
   wire enter_sleep;
   wire [7:0] op_addr;
   wire op_dest;
   wire op_borrow;
   wire [7:0] file_operand;
   wire [7:0] alu_result;
   wire alu_carry;
   wire alu_dcarry;
   wire alu_zero;
   wire file_wr_en;
   wire [7:0] file_wr_addr;
   wire [7:0] file_wr_data;
   wire [7:0] status_byte;

   assign setup_phase = PSEL & ~PENABLE;
   assign access_write = PSEL & PENABLE & PWRITE & pready_reg & ~pslverr_reg;
   assign addr_mapped = (PADDR == `OFS_CTRL) || (PADDR == `OFS_ACC) ||
                        (PADDR == `OFS_STATUS) || (PADDR == `OFS_FADDR) ||
                        (PADDR == `OFS_FDATA) || (PADDR == `OFS_RESULT);

   // A command write either requests sleep or issues one subtract.
   assign ctrl_write = access_write & (PADDR == `OFS_CTRL);
   assign enter_sleep = ctrl_write & PWDATA[`CTRL_SLEEP_BIT] & ~sleep_reg;
   // While asleep the core is halted, so commands are ignored.
   assign exec_sub = ctrl_write & ~PWDATA[`CTRL_SLEEP_BIT] & ~sleep_reg;
   assign op_addr = PWDATA[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
   assign op_dest = PWDATA[`CTRL_DEST_BIT];
   assign op_borrow = PWDATA[`CTRL_BORROW_BIT];
   assign file_operand = file_mem[op_addr];

   sub_borrow_alu #(
      .WIDTH(8)
   ) u_alu (
      .file_val(file_operand),
      .acc_val(acc_reg),
      .use_borrow(op_borrow),
      .carry_in(carry_flag_reg),
      .result(alu_result),
      .carry_out(alu_carry),
      .dcarry_out(alu_dcarry),
      .zero_out(alu_zero)
   );

   // File array write port: a subtract result or a direct software write.
   assign file_wr_en = (exec_sub & (op_dest == `DEST_FILE)) |
                       (access_write & (PADDR == `OFS_FDATA));
   assign file_wr_addr = exec_sub ? op_addr : faddr_reg;
   assign file_wr_data = exec_sub ? alu_result : PWDATA[7:0];

   assign status_byte = {3'h0, sleep_reg, powerdown_flag_reg, zero_flag_reg,
                         digit_carry_flag_reg, carry_flag_reg};

   // Bus handshake: the answer is prepared in the setup cycle, so the
   // first access cycle already sees PREADY high.
   always @* begin
      bus_state_next = bus_state_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      prdata_next = prdata_reg;
      case (bus_state_reg)
         BUS_IDLE: begin
            if (setup_phase) begin
               bus_state_next = BUS_ACCESS;
               pready_next = 1'b1;
               pslverr_next = ~addr_mapped;
               prdata_next = `WORD_ZERO;
               if (!PWRITE && addr_mapped) begin
                  case (PADDR)
                     `OFS_ACC: prdata_next = {24'h000000, acc_reg};
                     `OFS_STATUS: prdata_next = {24'h000000, status_byte};
                     `OFS_FADDR: prdata_next = {24'h000000, faddr_reg};
                     `OFS_FDATA: prdata_next = {24'h000000,
                                                file_mem[faddr_reg]};
                     `OFS_RESULT: prdata_next = {24'h000000, result_reg};
                     default: prdata_next = `WORD_ZERO;
                  endcase
               end
            end
         end
         BUS_ACCESS: begin
            bus_state_next = BUS_IDLE;
         end
         default: begin
            bus_state_next = BUS_IDLE;
         end
      endcase
   end

   // Architectural state update.
   always @* begin
      acc_next = acc_reg;
      carry_flag_next = carry_flag_reg;
      digit_carry_flag_next = digit_carry_flag_reg;
      zero_flag_next = zero_flag_reg;
      powerdown_flag_next = powerdown_flag_reg;
      sleep_next = sleep_reg;
      faddr_next = faddr_reg;
      result_next = result_reg;
      done_next = 1'b0;
      if (access_write && (PADDR == `OFS_ACC)) begin
         acc_next = PWDATA[7:0];
      end
      if (access_write && (PADDR == `OFS_FADDR)) begin
         faddr_next = PWDATA[7:0];
      end
      if (access_write && (PADDR == `OFS_STATUS)) begin
         carry_flag_next = PWDATA[`ST_CARRY_BIT];
         digit_carry_flag_next = PWDATA[`ST_DCARRY_BIT];
         zero_flag_next = PWDATA[`ST_ZERO_BIT];
         powerdown_flag_next = PWDATA[`ST_POWERDOWN_BIT];
      end
      // The whole subtract completes in the cycle the command is taken.
      if (exec_sub) begin
         carry_flag_next = alu_carry;
         digit_carry_flag_next = alu_dcarry;
         zero_flag_next = alu_zero;
         result_next = alu_result;
         done_next = 1'b1;
         if (op_dest == `DEST_ACC) begin
            acc_next = alu_result;
         end
      end
      // Sleep stops the oscillator and marks power-down; setting wins.
      if (enter_sleep) begin
         sleep_next = 1'b1;
         powerdown_flag_next = 1'b1;
      end else if (sleep_reg && EXT_WAKE_REQ) begin
         sleep_next = 1'b0;
      end
   end

   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         bus_state_reg <= BUS_IDLE;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= `WORD_ZERO;
         acc_reg <= `BYTE_ZERO;
         carry_flag_reg <= `FLAG_RST;
         digit_carry_flag_reg <= `FLAG_RST;
         zero_flag_reg <= `FLAG_RST;
         powerdown_flag_reg <= `FLAG_RST;
         sleep_reg <= `FLAG_RST;
         faddr_reg <= `BYTE_ZERO;
         result_reg <= `BYTE_ZERO;
         done_reg <= 1'b0;
      end else if (CE) begin
         bus_state_reg <= bus_state_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
         acc_reg <= acc_next;
         carry_flag_reg <= carry_flag_next;
         digit_carry_flag_reg <= digit_carry_flag_next;
         zero_flag_reg <= zero_flag_next;
         powerdown_flag_reg <= powerdown_flag_next;
         sleep_reg <= sleep_next;
         faddr_reg <= faddr_next;
         result_reg <= result_next;
         done_reg <= done_next;
      end
   end

   // The data memory is not reset, as a real register file would not be.
   always @(posedge CLOCK) begin
      if (CE && file_wr_en) begin
         file_mem[file_wr_addr] <= file_wr_data;
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign OSC_STOP = sleep_reg;
   assign POWERDOWN_FLAG = powerdown_flag_reg;
   assign SUB_DONE = done_reg;

endmodule // subtract_with_borrow_exec

//--- verif/subx_monitor.sv
`timescale 1ns/1ps
`include "subx_regs.vh"
module subx_monitor #(
   parameter ADDR_W = 12
) (
   // Clock and control.
   input logic CLOCK,
   input logic ARST_N,
   input logic CE,
   // Bus.
   input logic PSEL,
   input logic PENABLE,
   input logic PWRITE,
   input logic [ADDR_W-1:0] PADDR,
   input logic [31:0] PWDATA,
   input logic [31:0] PRDATA,
   input logic PREADY,
   input logic PSLVERR,
   // Power and status.
   input logic EXT_WAKE_REQ,
   input logic OSC_STOP,
   input logic POWERDOWN_FLAG,
   input logic SUB_DONE
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   wire cmd = PWRITE && PADDR == `OFS_CTRL;
   // A command write that the core executes as a subtract.
   wire exec_seen = cmd && PSEL && PENABLE && PREADY && CE &&
                    !PWDATA[`CTRL_SLEEP_BIT] && !OSC_STOP;
   sequence s_setup;
      PSEL && !PENABLE && CE;
   endsequence
   sequence s_access;
      PSEL && PENABLE && PREADY && CE;
   endsequence
   property p_ready;
      s_setup |=> PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   property p_once;
      PREADY |=> !PREADY;
   endproperty
   a_once: assert property (p_once) else $error("long ready");
   property p_done;
      s_setup ##1 s_access ##0 (cmd && !PWDATA[10] && !OSC_STOP) |=> SUB_DONE;
   endproperty
   a_done: assert property (p_done) else $error("no done");
   property p_cause;
      SUB_DONE |-> $past(exec_seen);
   endproperty
   a_cause: assert property (p_cause) else $error("stray done");
   property p_sleep;
      s_access ##0 (cmd && PWDATA[10]) |=> OSC_STOP && POWERDOWN_FLAG;
   endproperty
   a_sleep: assert property (p_sleep) else $error("no sleep");
   property p_wake;
      OSC_STOP && EXT_WAKE_REQ && CE && !PSEL |=> !OSC_STOP;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_pwrdn;
      $fell(OSC_STOP) |-> POWERDOWN_FLAG;
   endproperty
   a_pwrdn: assert property (p_pwrdn) else $error("flag lost");
   property p_err;
      s_setup ##0 (PADDR > `OFS_RESULT) |=> PSLVERR && PRDATA == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("no error");
endmodule // subx_monitor
bind subtract_with_borrow_exec subx_monitor #(.ADDR_W(ADDR_W)) u_subx_monitor (
   .CLOCK(CLOCK), .ARST_N(ARST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_WAKE_REQ(EXT_WAKE_REQ),
   .OSC_STOP(OSC_STOP), .POWERDOWN_FLAG(POWERDOWN_FLAG), .SUB_DONE(SUB_DONE));

//--- verif/apb_seq.sv
`timescale 1ns/1ps
`include "subx_regs.vh"
module apb_seq (
   // Clock and answer.
   input logic clk,
   input logic rdy,
   input logic err,
   input logic [31:0] rdata,
   // Request.
   output logic sel = 1'b0,
   output logic en = 1'b0,
   output logic wr = 1'b0,
   output logic [11:0] addr = 12'h000,
   output logic [31:0] wd = 32'h00000000
);
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge clk);
      sel <= 1'b1;
      wr <= w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      en <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      r = rdata;
      e = err;
      sel <= 1'b0;
      en <= 1'b0;
      addr <= ~a;
      wd <= ~d;
   endtask
   // No interrupt flag is pending here, and an idle cycle follows sleep.
   task sleep_cmd();
      logic [31:0] r;
      logic e;
      xfer(1'b1, `OFS_CTRL, 32'h00000400, r, e);
      @(posedge clk);
   endtask
endmodule // apb_seq

//--- verif/tb_subtract_with_borrow_exec.sv
`timescale 1ns/1ps
`include "subx_regs.vh"
module tb_subtract_with_borrow_exec;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic wake = 1'b0;
   wire sel, en, wr, rdy, err, osc, pwrdn, done;
   wire [11:0] addr;
   wire [31:0] wd, rdata;
   int errors = 0;
   int cmp_count = 0;
   int acc;
   logic [31:0] seed = 32'd17039;
   logic [31:0] r;
   logic e;
   apb_seq u_apb_seq(.clk(clk), .rdy(rdy), .err(err), .rdata(rdata),
      .sel(sel), .en(en), .wr(wr), .addr(addr), .wd(wd));
   subtract_with_borrow_exec u_subtract_with_borrow_exec(.CLOCK(clk),
      .ARST_N(arst_n), .CE(ce), .PSEL(sel), .PENABLE(en), .PWRITE(wr),
      .PADDR(addr), .PWDATA(wd), .PRDATA(rdata), .PREADY(rdy),
      .PSLVERR(err), .EXT_WAKE_REQ(wake), .OSC_STOP(osc),
      .POWERDOWN_FLAG(pwrdn), .SUB_DONE(done));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      cmp_count++;
      if (s !== x) begin
         errors++;
         $display("wrong value %s exp %h seen %h", n, x, s);
      end
   endtask
   task wr_reg(input logic [11:0] a, input logic [31:0] d);
      u_apb_seq.xfer(1'b1, a, d, r, e);
   endtask
   task rd_reg(input logic [11:0] a, input logic [31:0] x);
      u_apb_seq.xfer(1'b0, a, 32'h0, r, e);
      chk("rdata", r, x);
      chk("slverr", e, a > `OFS_RESULT);
   endtask
   task op(input int a, f, w, dst, brw, c);
      int d, lo, v;
      wr_reg(`OFS_FADDR, a);
      wr_reg(`OFS_FDATA, f);
      wr_reg(`OFS_ACC, w);
      wr_reg(`OFS_STATUS, c);
      wr_reg(`OFS_CTRL, a | dst << 8 | brw << 9);
      @(negedge clk);
      chk("done", done, 1);
      d = f - w - (brw & ~c & 1);
      lo = (f & 15) - (w & 15) - (brw & ~c & 1);
      v = d & 255;
      acc = dst ? w : v;
      rd_reg(`OFS_RESULT, v);
      rd_reg(`OFS_ACC, acc);
      rd_reg(`OFS_FDATA, dst ? v : f);
      rd_reg(`OFS_STATUS, (d >= 0) + 2 * (lo >= 0) + 4 * (v == 0));
   endtask
   task final_report;
      if (errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      #400000;
      errors++;
      final_report;
   end
   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      op(32, 'h33, 1, 1, 1, 1);
      op(33, 2, 1, 1, 1, 0);
      op(34, 4, 5, 1, 0, 0);
      op(255, 4, 5, 0, 0, 1);
      repeat (40) op(rnd() & 255, rnd() & 255, rnd() & 255, rnd() & 1,
         rnd() & 1, rnd() & 1);
      rd_reg(12'h018, 0);
      rd_reg(`OFS_CTRL, 0);
      u_apb_seq.sleep_cmd();
      chk("osc", osc, 1);
      chk("powerdown", pwrdn, 1);
      wr_reg(`OFS_ACC, 9);
      wr_reg(`OFS_CTRL, 0);
      @(negedge clk);
      chk("done", done, 0);
      rd_reg(`OFS_ACC, 9);
      // A low clock enable must hold the core asleep despite a wake request.
      ce <= 1'b0;
      wake <= 1'b1;
      repeat (3) @(posedge clk);
      chk("osc", osc, 1);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      wake <= 1'b0;
      chk("osc", osc, 0);
      chk("powerdown", pwrdn, 1);
      op(7, 9, 9, 0, 0, 1);
      final_report;
   end
endmodule // tb_subtract_with_borrow_exec
